/* File: tec_defines.svh */
// register indices, byte addresses, field positions and reset values of the timer/event counter
// assumes an APB slave with 32-bit data; byte address is four times the register index
`ifndef TEC_DEFINES_SVH
`define TEC_DEFINES_SVH

`define TEC_ADDR_W 18
`define TEC_IDX_COUNT 16'hFF10
`define TEC_IDX_CR0 16'hFF12
`define TEC_IDX_CR1 16'hFF14
`define TEC_IDX_MODE 16'hFFBA
`define TEC_IDX_PRE 16'hFFBB
`define TEC_IDX_CCC 16'hFFBC
`define TEC_IDX_TOC 16'hFFBD
`define TEC_BYTE(idx) {idx, 2'b00}

`define TEC_RST_16 16'h0000
`define TEC_RST_8 8'h00
`define TEC_CNT_MAX 16'hFFFF

// mode_control_reg fields
`define TEC_MODE_OVF 0
// capcmp_control_reg fields
`define TEC_CCC_F0 0
`define TEC_CCC_TRIG0 1
`define TEC_CCC_F1 2
// prescale_edge_reg fields
`define TEC_PRE_CLK_LO 0
`define TEC_PRE_CLK_HI 1
`define TEC_PRE_E0_LO 4
`define TEC_PRE_E0_HI 5
`define TEC_PRE_E1_LO 6
`define TEC_PRE_E1_HI 7
// output_control_reg fields
`define TEC_TOC_OE 0
`define TEC_TOC_INV0 1
`define TEC_TOC_LVR 2
`define TEC_TOC_LVS 3
`define TEC_TOC_INV1 4
`define TEC_TOC_OSPE 5
`define TEC_TOC_OSPT 6

// count clock dividers: fx/4 and fx/256
`define TEC_DIV4_MASK 8'h03
`define TEC_DIV256_MASK 8'hFF

`endif

/* File: tec_pkg.sv */
// types of the timer/event counter: run modes, count clock sources, edge codes and state
// assumes tec_defines.svh supplies the numeric constants
package tec_pkg;

   typedef enum logic [1:0] {
      TEC_RUN_STOP = 2'b00,
      TEC_RUN_FREE = 2'b01,
      TEC_RUN_EDGE_CLR = 2'b10,
      TEC_RUN_MATCH_CLR = 2'b11
   } tec_run_t;

   typedef enum logic [1:0] {
      TEC_CLK_FX = 2'b00,
      TEC_CLK_DIV4 = 2'b01,
      TEC_CLK_DIV256 = 2'b10,
      TEC_CLK_EDGE = 2'b11
   } tec_clk_t;

   typedef enum logic [1:0] {
      TEC_EDGE_FALL = 2'b00,
      TEC_EDGE_RISE = 2'b01,
      TEC_EDGE_BAD = 2'b10,
      TEC_EDGE_BOTH = 2'b11
   } tec_edge_t;

   typedef struct packed {
      logic [15:0] cnt;
      logic [15:0] cr0;
      logic [15:0] cr1;
      logic [2:0] mode;
      logic ovf;
      logic [2:0] ccc;
      logic [7:0] pre;
      logic [6:0] toc;
      logic lv;
      logic armed;
      logic [7:0] div;
      logic [1:0] sy1;
      logic [1:0] sy2;
      logic [1:0] sy3;
      logic irq0;
      logic irq1;
      logic wave;
      logic rdy;
      logic err;
      logic [31:0] rdata;
   } tec_state_t;

endpackage

/* File: tec_timer.sv */
// 16-bit timer/event counter with two capture/compare registers and a toggling output
// assumes an APB master on sys_clk_in; edge inputs are asynchronous pins and get synchronised here
//
// Overview of operation
// R1: counter is read-only; increments once per selected count clock while running.
// R2: counter clears on reset, stop, edge-clear edge, match-clear match, one-shot trigger.
// R3: register zero compares when its function bit is 0, captures when 1.
// R4: register one compares when control bit 2 is 0, captures when 1.
// R5: register zero compare raises its request on equality; value held until rewritten.
// R6: register one compare raises its own request on equality; value held until rewritten.
// R7: register zero on first input captures on opposite edge; none when both selected.
// R8: register zero on second input captures on that input's selected edge.
// R9: register one captures on the first input's selected edge.
// R10: software never programs edge code 10.
// R11: software loads register zero nonzero in match-clear mode.
// R12: register zero at zero matches on step zero to one after wrap.
// R13: register one at zero matches on step zero to one after overflow.
// R14: read coinciding with capture may return stale data; stored capture stays correct.
// R15: software rewrites register zero only while stopped; register one any time.
// R16: counting starts when upper mode bits leave 00, stops when returned to 00.
// R17: mode field selects stop, free-running, edge-clear or match-clear operation.
// R18: output toggles on enabled matches, also on first-input edge when lowest bit set.
// R19: requests come from matches or capture edges, never while stopped.
// R20: reset clears mode control and both capture/compare registers.
// R21: software avoids second-input edges while the shared pin drives the output.
// R22: with register zero at maximum in match-clear mode, the clear from maximum to zero does not set overflow.
// R23: external capture pulses last at least two count clocks longer.
// R24: overflow flag sets on every wrap and stays until software clears it.
`timescale 1ns/1ps
`include "tec_defines.svh"

module tec_timer (
   // clock and reset
   input wire logic sys_clk_in,
   input wire logic rst_n_in,
   // apb slave
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [`TEC_ADDR_W-1:0] paddr_in,
   input wire logic [31:0] pwdata_in,
   output logic [31:0] prdata_out,
   output logic pready_out,
   output logic pslverr_out,
   // external edge inputs
   input wire logic edge_input_first_in,
   input wire logic edge_input_second_in,
   // waveform output and requests
   output logic wave_output_pin_out,
   output logic match_irq_zero_out,
   output logic match_irq_one_out
);

   tec_pkg::tec_state_t st_r;
   tec_pkg::tec_state_t st_nxt;

   logic running;
   logic rise0, fall0, rise1, fall1;
   logic e0_valid, e0_rev, e1_valid;
   logic tick, clr, match0, match1;
   logic cap0, cap1, ovf_evt, oneshot;
   logic acc, wr;
   tec_pkg::tec_run_t run_mode;
   logic [`TEC_ADDR_W-1:0] a;

   // decodes an edge code into a valid-edge pulse; the forbidden code yields nothing
   function automatic logic edge_hit(input logic [1:0] sel, input logic rise, input logic fall);
      logic hit;
      hit = 1'b0;
      case (tec_pkg::tec_edge_t'(sel))
         tec_pkg::TEC_EDGE_FALL: hit = fall;
         tec_pkg::TEC_EDGE_RISE: hit = rise;
         tec_pkg::TEC_EDGE_BOTH: hit = rise | fall;
         default: hit = 1'b0;
      endcase
      return hit;
   endfunction

   // reverse-phase trigger for register zero on the first input
   function automatic logic edge_rev(input logic [1:0] sel, input logic rise, input logic fall);
      logic hit;
      hit = 1'b0;
      case (tec_pkg::tec_edge_t'(sel))
         tec_pkg::TEC_EDGE_FALL: hit = rise;
         tec_pkg::TEC_EDGE_RISE: hit = fall;
         default: hit = 1'b0;
      endcase
      return hit;
   endfunction

   always_comb begin
      st_nxt = st_r;
      a = paddr_in;

      // two-stage synchroniser, third stage only for edge detection
      st_nxt.sy1 = {edge_input_second_in, edge_input_first_in};
      st_nxt.sy2 = st_r.sy1;
      st_nxt.sy3 = st_r.sy2;
      rise0 = st_r.sy2[0] & ~st_r.sy3[0];
      fall0 = ~st_r.sy2[0] & st_r.sy3[0];
      rise1 = st_r.sy2[1] & ~st_r.sy3[1];
      fall1 = ~st_r.sy2[1] & st_r.sy3[1];

      run_mode = tec_pkg::tec_run_t'(st_r.mode[2:1]);
      running = run_mode != tec_pkg::TEC_RUN_STOP; // see R16
      e0_valid = running & edge_hit(st_r.pre[`TEC_PRE_E0_HI:`TEC_PRE_E0_LO], rise0, fall0);
      e0_rev = running & edge_rev(st_r.pre[`TEC_PRE_E0_HI:`TEC_PRE_E0_LO], rise0, fall0);
      e1_valid = running & edge_hit(st_r.pre[`TEC_PRE_E1_HI:`TEC_PRE_E1_LO], rise1, fall1);

      // apb: access phase lasts two cycles, the second one carries pready
      acc = psel_in & penable_in;
      wr = acc & pwrite_in & st_r.rdy;
      oneshot = wr && a == `TEC_BYTE(`TEC_IDX_TOC) && pwdata_in[`TEC_TOC_OSPT] && st_r.toc[`TEC_TOC_OSPE];

      // count clock selection; the prescaler runs free so a tick is a condition, not a clock
      st_nxt.div = st_r.div + 8'h01;
      case (tec_pkg::tec_clk_t'(st_r.pre[`TEC_PRE_CLK_HI:`TEC_PRE_CLK_LO]))
         tec_pkg::TEC_CLK_FX: tick = 1'b1;
         tec_pkg::TEC_CLK_DIV4: tick = (st_r.div & `TEC_DIV4_MASK) == `TEC_DIV4_MASK;
         tec_pkg::TEC_CLK_DIV256: tick = st_r.div == `TEC_DIV256_MASK;
         tec_pkg::TEC_CLK_EDGE: tick = e0_valid;
         default: tick = 1'b0;
      endcase
      tick = tick & running;

      // armed stays low right after a clear, so a compare value of zero only hits after a wrap
      match0 = tick & st_r.armed & ~st_r.ccc[`TEC_CCC_F0] & (st_r.cnt == st_r.cr0); // see R5 R12
      match1 = tick & st_r.armed & ~st_r.ccc[`TEC_CCC_F1] & (st_r.cnt == st_r.cr1); // see R6 R13

      case (run_mode)
         tec_pkg::TEC_RUN_STOP: clr = 1'b0;
         tec_pkg::TEC_RUN_FREE: clr = 1'b0;
         tec_pkg::TEC_RUN_EDGE_CLR: clr = e0_valid; // see R2 R17
         tec_pkg::TEC_RUN_MATCH_CLR: clr = match0; // see R2 R17
         default: clr = 1'b0;
      endcase
      clr = clr | (oneshot & running); // see R2

      if (!running) begin
         st_nxt.cnt = `TEC_RST_16; // see R2 R16
         st_nxt.armed = 1'b0;
      end else if (clr) begin
         st_nxt.cnt = `TEC_RST_16; // see R2
         st_nxt.armed = 1'b0;
      end else if (tick) begin
         st_nxt.cnt = st_r.cnt + 16'h0001; // see R1
         st_nxt.armed = 1'b1;
      end
      ovf_evt = tick & ~clr & (st_r.cnt == `TEC_CNT_MAX); // see R22 R24

      // captures take the counter as it stands before this edge's update
      cap0 = st_r.ccc[`TEC_CCC_F0] &
             (st_r.ccc[`TEC_CCC_TRIG0] ? e0_rev : e1_valid); // see R3 R7 R8
      cap1 = st_r.ccc[`TEC_CCC_F1] & e0_valid; // see R4 R9

      // requests are single-cycle pulses; all sources are already gated by running
      st_nxt.irq0 = match0 | cap0; // see R19
      st_nxt.irq1 = match1 | cap1; // see R19

      // output flip-flop
      if (running && ((match0 && st_r.toc[`TEC_TOC_INV0]) || (match1 && st_r.toc[`TEC_TOC_INV1]) ||
          (st_r.mode[0] && e0_valid))) begin
         st_nxt.lv = ~st_r.lv; // see R18
      end

      // software writes, taken at the edge that completes the access
      if (wr) begin
         case (a)
            `TEC_BYTE(`TEC_IDX_CR0): st_nxt.cr0 = pwdata_in[15:0];
            `TEC_BYTE(`TEC_IDX_CR1): st_nxt.cr1 = pwdata_in[15:0];
            `TEC_BYTE(`TEC_IDX_MODE): begin
               st_nxt.mode = pwdata_in[3:1];
               if (!pwdata_in[`TEC_MODE_OVF]) begin
                  st_nxt.ovf = 1'b0;
               end
            end
            `TEC_BYTE(`TEC_IDX_PRE): st_nxt.pre = {pwdata_in[7:4], 2'b00, pwdata_in[1:0]};
            `TEC_BYTE(`TEC_IDX_CCC): st_nxt.ccc = pwdata_in[2:0];
            `TEC_BYTE(`TEC_IDX_TOC): begin
               st_nxt.toc = {1'b0, pwdata_in[5:4], 2'b00, pwdata_in[1:0]};
               if (pwdata_in[`TEC_TOC_LVR]) begin
                  st_nxt.lv = 1'b0;
               end else if (pwdata_in[`TEC_TOC_LVS]) begin
                  st_nxt.lv = 1'b1;
               end
            end
            default: st_nxt.err = st_r.err;
         endcase
      end

      // hardware events win over a software write in the same cycle
      if (ovf_evt) begin
         st_nxt.ovf = 1'b1; // see R24
      end
      if (cap0) begin
         st_nxt.cr0 = st_r.cnt; // see R7 R8
      end
      if (cap1) begin
         st_nxt.cr1 = st_r.cnt; // see R9
      end

      st_nxt.wave = st_nxt.toc[`TEC_TOC_OE] & st_nxt.lv;

      // read data is sampled one cycle before pready, so a capture in between is not seen
      if (acc && !st_r.rdy) begin
         st_nxt.rdy = 1'b1;
         st_nxt.err = 1'b0;
         st_nxt.rdata = 32'h00000000;
         case (a)
            `TEC_BYTE(`TEC_IDX_COUNT): st_nxt.rdata = {16'h0000, st_r.cnt}; // see R1
            `TEC_BYTE(`TEC_IDX_CR0): st_nxt.rdata = {16'h0000, st_r.cr0}; // see R14
            `TEC_BYTE(`TEC_IDX_CR1): st_nxt.rdata = {16'h0000, st_r.cr1}; // see R14
            `TEC_BYTE(`TEC_IDX_MODE): st_nxt.rdata = {28'h0000000, st_r.mode, st_r.ovf};
            `TEC_BYTE(`TEC_IDX_PRE): st_nxt.rdata = {24'h000000, st_r.pre};
            `TEC_BYTE(`TEC_IDX_CCC): st_nxt.rdata = {29'h0, st_r.ccc};
            `TEC_BYTE(`TEC_IDX_TOC): st_nxt.rdata = {25'h0, st_r.toc};
            default: st_nxt.err = 1'b1;
         endcase
         if (pwrite_in && a == `TEC_BYTE(`TEC_IDX_COUNT)) begin
            st_nxt.err = 1'b1; // counter is read-only; see R1
            st_nxt.rdata = 32'h00000000;
         end
      end else begin
         st_nxt.rdy = 1'b0;
         st_nxt.err = 1'b0;
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (!rst_n_in) begin
         st_r <= '0; // see R20
      end else begin
         st_r <= st_nxt;
      end
   end

   assign prdata_out = st_r.rdata;
   assign pready_out = st_r.rdy;
   assign pslverr_out = st_r.err;
   assign wave_output_pin_out = st_r.wave;
   assign match_irq_zero_out = st_r.irq0;
   assign match_irq_one_out = st_r.irq1;

endmodule

/* File: tec_timer_monitor.sv */
// port checks for the timer/event counter
// assumes it is bound to tec_timer and sees only its ports
`timescale 1ns/1ps
`include "tec_defines.svh"
module tec_timer_monitor (
   // clock and reset
   input wire logic sys_clk_in,
   input wire logic rst_n_in,
   // apb
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [`TEC_ADDR_W-1:0] paddr_in,
   input wire logic [31:0] pwdata_in,
   input wire logic [31:0] prdata_out,
   input wire logic pready_out,
   input wire logic pslverr_out,
   // pins
   input wire logic edge_input_first_in,
   input wire logic edge_input_second_in,
   input wire logic wave_output_pin_out,
   input wire logic match_irq_zero_out,
   input wire logic match_irq_one_out
);
   default clocking cb @(posedge sys_clk_in);
   endclocking
   sequence s_wait;
      psel_in && penable_in && !pready_out;
   endsequence
   sequence s_answer;
      pready_out ##1 !pready_out;
   endsequence
   a_apb_answer: assert property (disable iff (!rst_n_in) s_wait |=> s_answer)
      else $error("apb answer late");
   a_ready_cause: assert property (disable iff (!rst_n_in) pready_out |-> psel_in && penable_in)
      else $error("ready without access");
   a_err_ready: assert property (disable iff (!rst_n_in) pslverr_out |-> pready_out)
      else $error("error without ready");
   a_err_data: assert property (disable iff (!rst_n_in) pslverr_out |-> prdata_out == 32'h0)
      else $error("error data not zero");
   a_reset_quiet: assert property (!rst_n_in |=> !pready_out && !match_irq_zero_out && !wave_output_pin_out)
      else $error("outputs active in reset");
   a_irq_zero_pulse: assert property (disable iff (!rst_n_in) match_irq_zero_out |=> !match_irq_zero_out)
      else $error("request zero too long");
   a_irq_one_pulse: assert property (disable iff (!rst_n_in) $rose(match_irq_one_out) |=> $fell(match_irq_one_out))
      else $error("request one too long");
   a_count_readonly: assert property (disable iff (!rst_n_in) pready_out && pwrite_in
      && paddr_in == `TEC_BYTE(`TEC_IDX_COUNT) |-> pslverr_out)
      else $error("counter write accepted");
endmodule
bind tec_timer tec_timer_monitor i_monitor (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .psel_in(psel_in),
   .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in),
   .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out),
   .edge_input_first_in(edge_input_first_in), .edge_input_second_in(edge_input_second_in),
   .wave_output_pin_out(wave_output_pin_out), .match_irq_zero_out(match_irq_zero_out),
   .match_irq_one_out(match_irq_one_out));

/* File: tec_pins_model.sv */
// edge sources and wave watcher at the timer pins
// assumes calls right after a rising clock edge
`timescale 1ns/1ps
module tec_pins_model (
   // clock
   input wire logic sys_clk_in,
   // timer output
   input wire logic wave_in,
   // edge sources
   output logic first_out,
   output logic second_out
);
   int toggles = 0;
   logic last = 1'b0;
   initial begin
      first_out = 1'b0;
      second_out = 1'b0;
   end
   always @(posedge sys_clk_in) begin
      if (wave_in !== last) toggles++;
      last <= wave_in;
   end
   task automatic drive_first(input logic level, input int hold);
      first_out <= level;
      repeat (hold) @(posedge sys_clk_in);
   endtask
endmodule

/* File: timer_event_counter_16bit_test.sv */
// bench for the timer/event counter: apb driver, queued read checks, pin model
// assumes tec_timer, its monitor and tec_pins_model are compiled first
`timescale 1ns/1ps
`include "tec_defines.svh"
module timer_event_counter_16bit_test;
   logic sys_clk_in = 1'b0;
   logic rst_n_in = 1'b0;
   logic psel_in = 1'b0;
   logic penable_in = 1'b0;
   logic pwrite_in = 1'b0;
   logic [`TEC_ADDR_W-1:0] paddr_in = '0;
   logic [31:0] pwdata_in = '0;
   logic [31:0] prdata_out;
   logic pready_out, pslverr_out, first, second, wave, irq0, irq1;
   int fails = 0;
   int comparisons = 0;
   int cycles = 0;
   int n1 = 0;
   int n0 = 0;
   int t0, tg, b0, b1;
   logic [33:0] notes[$];
   logic [33:0] note;
   logic [31:0] got, cap;
   logic [15:0] per;
   tec_timer i_dut (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .psel_in(psel_in), .penable_in(penable_in),
      .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in), .prdata_out(prdata_out),
      .pready_out(pready_out), .pslverr_out(pslverr_out), .edge_input_first_in(first),
      .edge_input_second_in(second), .wave_output_pin_out(wave), .match_irq_zero_out(irq0),
      .match_irq_one_out(irq1));
   tec_pins_model i_pins (.sys_clk_in(sys_clk_in), .wave_in(wave), .first_out(first), .second_out(second));
   initial begin
      forever #2.5 sys_clk_in = ~sys_clk_in;
   end
   task automatic report_and_stop();
      $display("comparisons %0d fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         fails++;
         $display("unexpected %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // note = {compare data, expected error, expected data}
   task automatic apb(input logic wr, input logic [15:0] idx, input logic [31:0] wd, input logic [33:0] nt);
      notes.push_back(nt);
      psel_in <= 1'b1;
      pwrite_in <= wr;
      paddr_in <= `TEC_BYTE(idx);
      pwdata_in <= wd;
      @(posedge sys_clk_in);
      penable_in <= 1'b1;
      do @(posedge sys_clk_in); while (pready_out !== 1'b1);
      got = prdata_out;
      psel_in <= 1'b0;
      penable_in <= 1'b0;
      @(posedge sys_clk_in);
   endtask
   task automatic wr(input logic [15:0] idx, input logic [31:0] d, input logic e);
      apb(1'b1, idx, d, {1'b0, e, 32'h0});
   endtask
   task automatic rd(input logic [15:0] idx, input logic [31:0] x, input logic e);
      apb(1'b0, idx, 32'h0, {1'b1, e, x});
   endtask
   always @(posedge sys_clk_in) begin
      cycles++;
      if (irq0 === 1'b1) n0++;
      if (irq1 === 1'b1) n1++;
      if (pready_out === 1'b1 && notes.size() > 0) begin
         note = notes.pop_front();
         check("pslverr", {31'h0, pslverr_out}, {31'h0, note[32]});
         if (note[33]) check("prdata", prdata_out, note[31:0]);
      end
      if (cycles > 80000) begin
         fails++;
         report_and_stop();
      end
   end
   initial begin
      void'($urandom(4));
      repeat (6) @(posedge sys_clk_in);
      rst_n_in <= 1'b1;
      @(posedge sys_clk_in);
      rd(`TEC_IDX_COUNT, 32'h0, 1'b0);
      rd(`TEC_IDX_CR0, 32'h0, 1'b0);
      rd(`TEC_IDX_CR1, 32'h0, 1'b0);
      rd(`TEC_IDX_MODE, 32'h0, 1'b0);
      wr(`TEC_IDX_COUNT, 32'h1234, 1'b1);
      rd(16'hFF00, 32'h0, 1'b1);
      per = 16'($urandom_range(40, 8));
      wr(`TEC_IDX_CR0, {16'h0, per}, 1'b0);
      wr(`TEC_IDX_CR1, {17'h0, per[15:1]}, 1'b0);
      wr(`TEC_IDX_TOC, 32'h13, 1'b0);
      b0 = n0;
      b1 = n1;
      tg = i_pins.toggles;
      wr(`TEC_IDX_MODE, 32'h0C, 1'b0);
      t0 = n0;
      repeat (int'(per) + 3) @(posedge sys_clk_in);
      check("period", n0 - t0, 1);
      repeat (4 * (int'(per) + 1)) @(posedge sys_clk_in);
      // stop just after a match of register zero, well before register one matches again
      @(posedge sys_clk_in iff irq0 === 1'b1);
      wr(`TEC_IDX_MODE, 32'h0, 1'b0);
      rd(`TEC_IDX_COUNT, 32'h0, 1'b0);
      rd(`TEC_IDX_CR0, {16'h0, per}, 1'b0);
      check("match one", n1 - b1, n0 - b0);
      // both inversions enabled, so every match toggles the output once
      t0 = (n0 - b0) + (n1 - b1);
      b0 = n0 + n1;
      repeat (50) @(posedge sys_clk_in);
      check("stopped irq", n0 + n1, b0);
      check("toggles", i_pins.toggles - tg, t0);
      wr(`TEC_IDX_CCC, 32'h4, 1'b0);
      wr(`TEC_IDX_PRE, 32'h10, 1'b0);
      wr(`TEC_IDX_MODE, 32'h04, 1'b0);
      b1 = n1;
      repeat (20) @(posedge sys_clk_in);
      i_pins.drive_first(1'b1, 6);
      apb(1'b0, `TEC_IDX_CR1, 32'h0, 34'h0);
      cap = got;
      apb(1'b0, `TEC_IDX_COUNT, 32'h0, 34'h0);
      check("capture", {31'h0, cap != 0 && cap < got}, 32'h1);
      i_pins.drive_first(1'b0, 6);
      check("capture count", n1 - b1, 1);
      wr(`TEC_IDX_MODE, 32'h0, 1'b0);
      wr(`TEC_IDX_CCC, 32'h0, 1'b0);
      wr(`TEC_IDX_CR0, 32'hFFFF, 1'b0);
      wr(`TEC_IDX_CR1, 32'h0, 1'b0);
      wr(`TEC_IDX_MODE, 32'h04, 1'b0);
      t0 = cycles;
      b1 = n1;
      while (n1 == b1 && cycles < t0 + 70000) @(posedge sys_clk_in);
      check("wrap match", {31'h0, cycles - t0 > 65530 && cycles - t0 < 65545}, 32'h1);
      rd(`TEC_IDX_MODE, 32'h05, 1'b0);
      wr(`TEC_IDX_MODE, 32'h04, 1'b0);
      rd(`TEC_IDX_MODE, 32'h04, 1'b0);
      report_and_stop();
   end
endmodule
